/* File: src/discrepancy_pkg.sv */
/*
  Constants for the dual-channel discrepancy monitor: register map, field
  layout, reset values, pair modes, pair states and tick timing.
  Assumes a 250 MHz system clock and a register port with 32-bit words.
*/
package discrepancy_pkg;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_DISC_LIMIT = 8'h04;
  localparam logic [7:0] REG_SYNC_LIMIT = 8'h08;
  localparam logic [7:0] REG_STATUS     = 8'h0c;
  localparam logic [7:0] REG_TIMERS     = 8'h10;

  // Control field positions
  localparam int CTRL_MODE12_LSB = 0;
  localparam int CTRL_MODE34_LSB = 2;
  localparam int CTRL_SHARED12   = 4;
  localparam int CTRL_SHARED34   = 5;
  localparam int CTRL_SYNC_EN    = 6;
  localparam int CTRL_TWO_HAND   = 7;
  localparam int CTRL_WIDTH      = 8;

  // Status field positions
  localparam int STAT_STATE12_LSB = 0;
  localparam int STAT_STATE34_LSB = 3;
  localparam int STAT_DISC12      = 6;
  localparam int STAT_DISC34      = 7;
  localparam int STAT_SYNC_ERR    = 8;
  localparam int STAT_FAULT       = 9;
  localparam int STAT_ENABLE      = 10;
  localparam int STAT_PAIR12_OUT  = 11;
  localparam int STAT_PAIR34_OUT  = 12;

  // Limits are held in ticks of 10 ms; zero means not monitored
  localparam int             LIMIT_WIDTH   = 12;
  localparam logic [11:0]    LIMIT_MAX     = 12'hbb8;
  localparam logic [7:0]     CTRL_RESET    = 8'h00;
  localparam logic [11:0]    LIMIT_RESET   = 12'h000;

  // Evaluation tick: 10 ms step at a 4 ns clock
  localparam longint TICK_PERIOD_NS = 10_000_000;
  localparam longint CLK_PERIOD_NS  = 4;
  localparam int     TICK_CYCLES    = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_EQUIV  = 2'h1,
    MODE_COMPL  = 2'h2
  } pair_mode_t;

  typedef enum logic [1:0] {
    CLS_INACTIVE   = 2'h0,
    CLS_ACTIVE     = 2'h1,
    CLS_DISCREPANT = 2'h2
  } pair_class_t;

  // Gray order along the usual path
  typedef enum logic [2:0] {
    ST_INACTIVE  = 3'h0,
    ST_RISING    = 3'h1,
    ST_ACTIVE    = 3'h3,
    ST_FALLING   = 3'h2,
    ST_ERROR     = 3'h6
  } pair_state_t;

endpackage

/* File: src/dual_channel_discrepancy_monitor.sv */
/*
  Dual-channel discrepancy monitor: evaluates two input pairs as single,
  equivalent or complementary channels, runs a discrepancy timer per pair
  and a synchronization timer between the pairs, and derives fault present
  and output enable. Also holds the plain inverter block.
  Assumes channel pins are asynchronous to clk_in, the inverter source is
  on clk_in, and software uses the one-cycle strobe register port.
*/
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R1] Equivalent mode: opposite levels past the limit is an error.
// [R2] Complementary mode: equal levels past the limit is an error.
// [R3] Timer starts at first channel change; expiry without valid state errors.
// [R4] Equivalent 00/11 inactive/active, complementary 01/10; others discrepant.
// [R5] Single-channel input never runs discrepancy monitoring.
// [R6] Latched discrepancy error clears only once the pair is inactive.
// [R7] Active is entered only from inactive with the timer unexpired.
// [R8] Active, then discrepant, must pass inactive before active again.
// [R9] Limit is disabled or 10 ms to 30000 ms in 10 ms steps.
// [R10] Configurer picks an enabled limit longer than the scan period.
// [R11] Discrepancy error: enable off, fault on, flag of pair 1/2 or 3/4.
// [R12] A pair change starts sync timer; other pair must match before expiry.
// [R13] Sync holds only while neither pair shows fault or discrepancy.
// [R14] Sync expiry sets sync error; fault too unless two-hand variant.
// [R15] Fault present goes active on any configured monitoring error.
// [R16] Fault present holds output enable inactive.
// [R17] Remote status qualifier bits do not feed fault present.
// [R18] Inverter output is the complement of its single input.
// [R19] Inverter has no fault monitoring and no fault or reset outputs.
// [R20] Each block output goes to at most one physical output.
// [R21] Active fault forces evaluated outputs to zero; else pair decode.
// [R22] One source on both channels: first connection is the result.
// [R23] Timers count 10 ms ticks and clear on system reset.
module dual_channel_discrepancy_monitor
  import discrepancy_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  // Safety channels from pins: [0]=1A [1]=1B [2]=2A [3]=2B
  input  wire logic [3:0]  channel_in,
  // Inverter block
  input  wire logic        invert_src_in,
  output logic             invert_out,
  // Evaluation results
  output logic             pair12_out,
  output logic             pair34_out,
  output logic             output_enable_out,
  output logic             fault_present_out,
  output logic             disc_error12_out,
  output logic             disc_error34_out,
  output logic             sync_error_out,
  output logic             tick_out
);

  localparam int TICK_W = $clog2(TICK_COUNT + 1);

  // Pair class from the two channel levels
  function automatic pair_class_t classify(input pair_mode_t mode,
                                           input logic shared,
                                           input logic a,
                                           input logic b);
    pair_class_t cls;
    cls = CLS_INACTIVE;
    // [R22] first connection wins
    if (mode == MODE_SINGLE || shared) begin
      cls = a ? CLS_ACTIVE : CLS_INACTIVE;
    end else if (mode == MODE_EQUIV) begin
      // [R4] equivalent decode
      if (a == b) begin
        cls = a ? CLS_ACTIVE : CLS_INACTIVE;
      end else begin
        cls = CLS_DISCREPANT;
      end
    end else begin
      // [R4] complementary decode
      if (a != b) begin
        cls = a ? CLS_ACTIVE : CLS_INACTIVE;
      end else begin
        cls = CLS_DISCREPANT;
      end
    end
    return cls;
  endfunction

  // Mode code 3 is treated as single channel
  function automatic pair_mode_t mode_of(input logic [1:0] code);
    pair_mode_t m;
    case (code)
      2'h1:    m = MODE_EQUIV;
      2'h2:    m = MODE_COMPL;
      default: m = MODE_SINGLE;
    endcase
    return m;
  endfunction

  // [R9] disabled or 1..3000 ticks
  function automatic logic limit_ok(input logic [31:0] value);
    return value[31:LIMIT_WIDTH] == '0 &&
           value[LIMIT_WIDTH-1:0] <= LIMIT_MAX;
  endfunction

  logic [3:0]             sync_meta;
  logic [3:0]             chan;
  logic [CTRL_WIDTH-1:0]  ctrl;
  logic [LIMIT_WIDTH-1:0] disc_limit;
  logic [LIMIT_WIDTH-1:0] sync_limit;
  logic [TICK_W-1:0]      tick_count;
  logic                   tick;
  pair_state_t            state [2];
  pair_state_t            next_state [2];
  logic [LIMIT_WIDTH-1:0] disc_timer [2];
  logic [LIMIT_WIDTH-1:0] sync_timer;
  logic [1:0]             disc_err;
  logic [1:0]             disc_expired;
  logic [1:0]             monitored;
  logic [1:0]             pair_active;
  pair_class_t            cls [2];
  pair_mode_t             mode [2];
  logic                   sync_err;
  logic                   sync_ok;
  logic                   sync_expired;
  logic                   fault;
  logic                   enable;

  // Channel pins are asynchronous: two stages before use
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_meta <= 4'h0;
      chan      <= 4'h0;
    end else begin
      sync_meta <= channel_in;
      chan      <= sync_meta;
    end
  end

  // [R23] evaluation tick from the system clock
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else if (tick_count == TICK_W'(TICK_COUNT - 1)) begin
      tick_count <= '0;
      tick       <= 1'b1;
    end else begin
      tick_count <= tick_count + 1'b1;
      tick       <= 1'b0;
    end
  end

  // Configuration writes
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl       <= CTRL_RESET;
      disc_limit <= LIMIT_RESET;
      sync_limit <= LIMIT_RESET;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        REG_CTRL: begin
          ctrl <= reg_wdata_in[CTRL_WIDTH-1:0];
        end
        // [R9] out-of-range limits are refused
        REG_DISC_LIMIT: begin
          if (limit_ok(reg_wdata_in)) begin
            disc_limit <= reg_wdata_in[LIMIT_WIDTH-1:0];
          end
        end
        REG_SYNC_LIMIT: begin
          if (limit_ok(reg_wdata_in)) begin
            sync_limit <= reg_wdata_in[LIMIT_WIDTH-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign mode[0] = mode_of(ctrl[CTRL_MODE12_LSB +: 2]);
  assign mode[1] = mode_of(ctrl[CTRL_MODE34_LSB +: 2]);
  assign cls[0]  = classify(mode[0], ctrl[CTRL_SHARED12], chan[0], chan[1]);
  assign cls[1]  = classify(mode[1], ctrl[CTRL_SHARED34], chan[2], chan[3]);

  // Per-pair evaluation
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      // [R5] single channel or shared source is never monitored
      monitored[p] = mode[p] != MODE_SINGLE && !ctrl[CTRL_SHARED12 + p] &&
                     disc_limit != '0;
      // [R1] [R2] [R3] expiry of a running discrepancy timer
      disc_expired[p] = monitored[p] && disc_timer[p] >= disc_limit &&
                        (state[p] == ST_RISING || state[p] == ST_FALLING);
      next_state[p] = state[p];
      case (state[p])
        ST_INACTIVE: begin
          if (cls[p] == CLS_ACTIVE) begin
            next_state[p] = ST_ACTIVE;
          end else if (cls[p] == CLS_DISCREPANT) begin
            next_state[p] = ST_RISING;
          end
        end
        ST_RISING: begin
          // [R7] active only from inactive with timer unexpired
          if (disc_expired[p]) begin
            next_state[p] = ST_ERROR;
          end else if (cls[p] == CLS_ACTIVE) begin
            next_state[p] = ST_ACTIVE;
          end else if (cls[p] == CLS_INACTIVE) begin
            next_state[p] = ST_INACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (cls[p] == CLS_INACTIVE) begin
            next_state[p] = ST_INACTIVE;
          end else if (cls[p] == CLS_DISCREPANT) begin
            next_state[p] = ST_FALLING;
          end
        end
        ST_FALLING: begin
          // [R8] back to active levels is not enough
          if (disc_expired[p]) begin
            next_state[p] = ST_ERROR;
          end else if (cls[p] == CLS_INACTIVE) begin
            next_state[p] = ST_INACTIVE;
          end
        end
        ST_ERROR: begin
          // [R6] error clears only at inactive
          if (cls[p] == CLS_INACTIVE) begin
            next_state[p] = ST_INACTIVE;
          end
        end
        default: begin
          next_state[p] = ST_ERROR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state[0] <= ST_INACTIVE;
      state[1] <= ST_INACTIVE;
    end else begin
      state[0] <= next_state[0];
      state[1] <= next_state[1];
    end
  end

  // [R3] [R23] discrepancy timers run in ticks while a pair is in transit
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      disc_timer[0] <= '0;
      disc_timer[1] <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (next_state[p] != ST_RISING && next_state[p] != ST_FALLING) begin
          disc_timer[p] <= '0;
        end else if (state[p] == ST_INACTIVE || state[p] == ST_ACTIVE) begin
          disc_timer[p] <= '0;
        end else if (tick && disc_timer[p] != '1) begin
          disc_timer[p] <= disc_timer[p] + 1'b1;
        end
      end
    end
  end

  // [R11] error flag of the offending pair
  assign disc_err[0]    = state[0] == ST_ERROR;
  assign disc_err[1]    = state[1] == ST_ERROR;
  assign pair_active[0] = state[0] == ST_ACTIVE;
  assign pair_active[1] = state[1] == ST_ACTIVE;

  // [R12] [R13] pairs agree and neither is in error
  assign sync_ok = pair_active[0] == pair_active[1] && disc_err == 2'h0 &&
                   (state[0] == ST_INACTIVE || state[0] == ST_ACTIVE) &&
                   (state[1] == ST_INACTIVE || state[1] == ST_ACTIVE);
  assign sync_expired = ctrl[CTRL_SYNC_EN] && sync_limit != '0 &&
                        !sync_ok && sync_timer >= sync_limit;

  // [R12] [R23] synchronization timer between the pairs
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_timer <= '0;
    end else if (sync_ok || !ctrl[CTRL_SYNC_EN]) begin
      sync_timer <= '0;
    end else if (tick && sync_timer != '1) begin
      sync_timer <= sync_timer + 1'b1;
    end
  end

  // [R14] latched sync error, cleared once both pairs rest inactive
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_err <= 1'b0;
    end else if (sync_expired) begin
      sync_err <= 1'b1;
    end else if (state[0] == ST_INACTIVE && state[1] == ST_INACTIVE) begin
      sync_err <= 1'b0;
    end
  end

  // [R15] [R17] fault from monitoring checks only
  // [R14] two-hand variant keeps sync error out of fault
  assign fault = disc_err[0] || disc_err[1] ||
                 (sync_err && !ctrl[CTRL_TWO_HAND]);

  // [R16] [R21] fault forces the enable low
  always_comb begin
    if (fault) begin
      enable = 1'b0;
    end else if (ctrl[CTRL_SYNC_EN]) begin
      enable = pair_active[0] && pair_active[1] && !sync_err;
    end else begin
      enable = pair_active[0];
    end
  end

  // [R11] [R21] registered outputs
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pair12_out        <= 1'b0;
      pair34_out        <= 1'b0;
      output_enable_out <= 1'b0;
      fault_present_out <= 1'b0;
      disc_error12_out  <= 1'b0;
      disc_error34_out  <= 1'b0;
      sync_error_out    <= 1'b0;
      tick_out          <= 1'b0;
    end else begin
      pair12_out        <= pair_active[0] && !fault;
      pair34_out        <= pair_active[1] && !fault;
      output_enable_out <= enable;
      fault_present_out <= fault;
      disc_error12_out  <= disc_err[0];
      disc_error34_out  <= disc_err[1];
      sync_error_out    <= sync_err;
      tick_out          <= tick;
    end
  end

  // [R18] [R19] plain inverter, no monitoring
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      invert_out <= 1'b1;
    end else begin
      invert_out <= !invert_src_in;
    end
  end

  // Read data valid only in the cycle after the read strobe
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_read_in) begin
      reg_rdata_out <= 32'h0000_0000;
      case (reg_addr_in)
        REG_CTRL: begin
          reg_rdata_out[CTRL_WIDTH-1:0] <= ctrl;
        end
        REG_DISC_LIMIT: begin
          reg_rdata_out[LIMIT_WIDTH-1:0] <= disc_limit;
        end
        REG_SYNC_LIMIT: begin
          reg_rdata_out[LIMIT_WIDTH-1:0] <= sync_limit;
        end
        REG_STATUS: begin
          reg_rdata_out[STAT_STATE12_LSB +: 3] <= state[0];
          reg_rdata_out[STAT_STATE34_LSB +: 3] <= state[1];
          reg_rdata_out[STAT_DISC12]           <= disc_err[0];
          reg_rdata_out[STAT_DISC34]           <= disc_err[1];
          reg_rdata_out[STAT_SYNC_ERR]         <= sync_err;
          reg_rdata_out[STAT_FAULT]            <= fault;
          reg_rdata_out[STAT_ENABLE]           <= enable;
          reg_rdata_out[STAT_PAIR12_OUT]       <= pair_active[0] && !fault;
          reg_rdata_out[STAT_PAIR34_OUT]       <= pair_active[1] && !fault;
        end
        REG_TIMERS: begin
          reg_rdata_out[LIMIT_WIDTH-1:0]      <= disc_timer[0];
          reg_rdata_out[16 +: LIMIT_WIDTH]    <= disc_timer[1];
        end
        default: begin
        end
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

endmodule // dual_channel_discrepancy_monitor

`default_nettype wire

/* File: testbench/discrepancy_chk.sv */
/*
  Port checker for the dual-channel discrepancy monitor.
  Bound onto the top module; sees only its ports, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module discrepancy_chk #(
  parameter int TICK_COUNT = 4
) (
  // Clock, reset and register port
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  // Pins and inverter
  input wire logic [3:0]  channel_in,
  input wire logic        invert_src_in,
  input wire logic        invert_out,
  // Evaluation results
  input wire logic        pair12_out,
  input wire logic        pair34_out,
  input wire logic        output_enable_out,
  input wire logic        fault_present_out,
  input wire logic        disc_error12_out,
  input wire logic        disc_error34_out,
  input wire logic        sync_error_out,
  input wire logic        tick_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  int   gap;
  logic seen;

  // Gap is only meaningful once a first tick has been seen
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap  <= 0;
      seen <= 1'b0;
    end else if (tick_out) begin
      gap  <= 0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end

  sequence s_quiet;
    ##1 !tick_out;
  endsequence

  // Pin A is low in the inactive code of both pair modes
  sequence s_a_was_low;
    !$past(channel_in[0], 3) || !$past(channel_in[0], 4);
  endsequence

  inv_comp_a: assert property (
    $past(reset_n_in) |-> invert_out == !$past(invert_src_in))
    else $error("inverter output is not the complement");
  fault_gate_a: assert property (
    fault_present_out |-> !output_enable_out)
    else $error("enable high while fault present");
  disc_fault_a: assert property (
    (disc_error12_out || disc_error34_out) |-> fault_present_out)
    else $error("discrepancy error without fault present");
  fault_zero_a: assert property (
    fault_present_out |-> !pair12_out && !pair34_out)
    else $error("pair result high while fault present");
  disc_clear_a: assert property (
    $fell(disc_error12_out) |-> s_a_was_low)
    else $error("discrepancy error cleared outside inactive");
  sync_block_a: assert property (
    sync_error_out |-> !output_enable_out)
    else $error("enable high with sync error");
  enable_pair_a: assert property (
    output_enable_out |-> pair12_out)
    else $error("enable high without pair result");
  tick_gap_a: assert property (
    tick_out && seen |-> gap == TICK_COUNT - 1)
    else $error("tick spacing wrong");
  tick_pulse_a: assert property (
    tick_out |-> s_quiet)
    else $error("tick longer than one cycle");
  rdata_idle_a: assert property (
    !$past(reg_read_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside its cycle");
endmodule // discrepancy_chk

bind dual_channel_discrepancy_monitor discrepancy_chk #(
  .TICK_COUNT(TICK_COUNT)
) chk_i (
  .clk_in, .reset_n_in, .reg_read_in, .reg_rdata_out, .channel_in,
  .invert_src_in, .invert_out, .pair12_out, .pair34_out,
  .output_enable_out, .fault_present_out, .disc_error12_out,
  .disc_error34_out, .sync_error_out, .tick_out
);
`default_nettype wire

/* File: testbench/sensor_model.sv */
/*
  Behavioural safety sensors on the four channel pins.
  A contacts follow the target one cycle late; B contacts lag a
  further lag_in cycles, so the two contacts switch together only when lag_in is 0.
*/
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
  // Clock
  input  wire logic       clk_in,
  // Target levels and contact lag
  input  wire logic [3:0] target_in,
  input  wire logic [1:0] lag_in,
  // Pins
  output var  logic [3:0] channel_out
);
  logic [3:0] hist [4] = '{default: 4'h0};

  always @(posedge clk_in) begin
    hist[0] <= target_in;
    for (int i = 1; i < 4; i++) hist[i] <= hist[i-1];
  end

  assign channel_out = {hist[lag_in][3], hist[0][2],
                        hist[lag_in][1], hist[0][0]};
endmodule // sensor_model
`default_nettype wire

/* File: testbench/tb.sv */
/*
  Self-checking bench for the dual-channel discrepancy monitor.
  Drives the register port and the sensor model; a small model of
  registers and pair decode gives the limit read-back and decode expectations; the other tests use fixed values. Tick is 4.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import discrepancy_pkg::*;
  localparam int TK = 4;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [3:0]  target = 4'h0;
  logic [1:0]  lag = 2'h0;
  logic [3:0]  chan;
  logic        src = 1'b0;
  logic        src_q = 1'b0;
  logic        inv, p12, p34, en, flt, d12, d34, serr, tick;
  logic [6:0]  obs;
  logic [31:0] rm [4] = '{default: 32'h0};
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          seed = 27088;

  assign obs = {serr, d34, d12, flt, en, p34, p12};
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) src <= 1'($random(seed));
  always @(posedge clk_in) src_q <= src;

  sensor_model sens (.clk_in(clk_in), .target_in(target), .lag_in(lag),
                     .channel_out(chan));
  dual_channel_discrepancy_monitor #(.TICK_COUNT(TK)) uut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .reg_rdata_out(rdata), .channel_in(chan), .invert_src_in(src),
    .invert_out(inv), .pair12_out(p12), .pair34_out(p34),
    .output_enable_out(en), .fault_present_out(flt),
    .disc_error12_out(d12), .disc_error34_out(d34),
    .sync_error_out(serr), .tick_out(tick));

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_flags(input logic [6:0] e);
    n_compared++;
    if (obs !== e) begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, obs);
    end
  endtask

  task automatic chk_inv(input logic e);
    n_compared++;
    if (inv !== e) begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, inv);
    end
  endtask

  // Inverter model: complement of the source seen at the last edge
  always @(negedge clk_in) begin
    if (cyc > 21) chk_inv(!src_q);
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wait_flags(input logic [6:0] e, input int maxc);
    for (int i = 0; i < maxc; i++) begin
      settle(1);
      if (obs === e) break;
    end
    chk_flags(e);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    // Limits above the maximum are refused silently
    if (a == REG_CTRL || d <= 32'(LIMIT_MAX)) rm[a[3:2]] = d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk_reg(e, rdata);
  endtask

  task automatic cfg(input logic [7:0] c, input int dl, input int sl);
    reg_wr(REG_CTRL, {24'h0, c});
    reg_wr(REG_DISC_LIMIT, 32'(dl));
    reg_wr(REG_SYNC_LIMIT, 32'(sl));
  endtask

  task automatic drive(input logic [3:0] t);
    @(posedge clk_in);
    target <= t;
    lag <= 2'($random(seed));
  endtask

  function automatic logic active(input int m, input int ba);
    return (m == MODE_EQUIV) ? (ba == 3) : (ba == 1);
  endfunction

  initial begin
    int q[$];
    logic [31:0] v;
    logic e;
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int a = 0; a < 6; a++) reg_rd(8'(a * 4), 32'h0);
    chk_flags(7'h00);
    $display("test reset done");

    reg_wr(REG_DISC_LIMIT, 32'h0bb9);
    reg_rd(REG_DISC_LIMIT, rm[1]);
    for (int i = 0; i < 4; i++) begin
      v = 32'(1 + ($unsigned($random(seed)) % 3000));
      reg_wr(REG_SYNC_LIMIT, v);
      reg_rd(REG_SYNC_LIMIT, rm[2]);
    end
    reg_wr(REG_DISC_LIMIT, 32'(LIMIT_MAX));
    reg_rd(REG_DISC_LIMIT, rm[1]);
    $display("test limits done");

    for (int m = 1; m < 3; m++) begin
      cfg(8'(m * 5), 0, 0);
      if (m == 1) begin
        q = {0, 2, 1, 3, 0};
      end else begin
        q = {2, 0, 3, 1, 2};
      end
      foreach (q[i]) begin
        drive({2'(q[i]), 2'(q[i])});
        e = active(m, q[i]);
        wait_flags({4'h0, e, e, e}, 16);
      end
    end
    $display("test decode done");

    cfg(8'h05, 100, 0);
    q = {3, 1, 3, 0, 3, 0};
    foreach (q[i]) begin
      drive({2'(q[i]), 2'(q[i])});
      e = (i == 0 || i == 4);
      settle(16);
      chk_flags({4'h0, e, e, e});
    end
    $display("test reentry done");

    cfg(8'h05, 3, 0);
    for (int p = 0; p < 2; p++) begin
      drive(4'h1 << (2 * p));
      settle(8);
      chk_flags(7'h00);
      wait_flags(p ? 7'h28 : 7'h18, 24);
      drive(4'h3 << (2 * p));
      settle(16);
      chk_flags(p ? 7'h28 : 7'h18);
      reg_rd(REG_STATUS, 32'(ST_ERROR) << (STAT_STATE34_LSB * p) |
             32'h1 << (STAT_DISC12 + p) | 32'h1 << STAT_FAULT);
      drive(4'h0);
      wait_flags(7'h00, 24);
    end
    $display("test equivalent error done");

    cfg(8'h0a, 0, 0);
    drive(4'ha);
    wait_flags(7'h00, 16);
    reg_wr(REG_DISC_LIMIT, 32'h3);
    drive(4'hb);
    wait_flags(7'h18, 40);
    drive(4'ha);
    wait_flags(7'h00, 24);
    $display("test complementary error done");

    cfg(8'h0c, 1, 0);
    drive(4'h5);
    settle(24);
    chk_flags(7'h07);
    reg_wr(REG_CTRL, 32'h11);
    settle(24);
    chk_flags(7'h07);
    drive(4'h0);
    wait_flags(7'h00, 16);
    $display("test single done");

    cfg(8'h45, 0, 2);
    drive(4'hf);
    wait_flags(7'h07, 16);
    drive(4'h0);
    wait_flags(7'h00, 16);
    drive(4'h3);
    wait_flags(7'h48, 40);
    drive(4'h0);
    wait_flags(7'h00, 40);
    reg_wr(REG_CTRL, 32'hc5);
    drive(4'h3);
    wait_flags(7'h41, 40);
    drive(4'h0);
    wait_flags(7'h00, 40);
    $display("test sync done");
    summarize();
  end
endmodule // tb
`default_nettype wire
